// >>> biphase_twinax_and_byte_framer_tb.sv
// Bench of the byte framer
`timescale 1ns/1ps
module biphase_twinax_and_byte_framer_tb;
    logic        clk_sys;
    logic        resetn;
    logic [2:0]  reg_addr;
    logic        reg_wr;
    logic [15:0] reg_wdata;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic        ser_in;
    logic        line_activity_indicator;
    logic        ser_out;
    logic        line_driver_active;
    logic        dec_ser_in;
    logic        dec_hunt;
    logic        rx_valid;
    logic [15:0] rx_frame;
    logic        rx_err;
    logic        rx_fill_lost;
    logic [15:0] v;
    logic [63:0] bits;
    int          miscompares;
    int          num_checks;
    int          cycles;
    int          d0;
    int          d1;
    int          d2;
    localparam logic [2:0] DAT = btf_pkg::A_DATA;
    localparam logic [2:0] STA = btf_pkg::A_STAT;
    localparam logic [2:0] MOD = btf_pkg::A_MODE;

    btf_framer dut (
        .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ser_in(ser_in),
        .line_activity_indicator(line_activity_indicator),
        .ser_out(ser_out), .line_driver_active(line_driver_active),
        .dec_ser_in(dec_ser_in), .dec_hunt(dec_hunt),
        .rx_valid(rx_valid), .rx_frame(rx_frame), .rx_err(rx_err),
        .rx_fill_lost(rx_fill_lost));
    btf_remote rem (
        .clk_sys(clk_sys), .ser_in(ser_in),
        .line_activity_indicator(line_activity_indicator),
        .rx_valid(rx_valid), .rx_frame(rx_frame), .rx_err(rx_err),
        .rx_fill_lost(rx_fill_lost));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Expected line words
    function automatic logic [15:0] tw(input logic [7:0] d,
                                       input logic [3:0] c);
        return {1'b1, d, c[2:0], ^{1'b1, d, c[2:0]} ^ c[3], 3'b000};
    endfunction
    function automatic logic [15:0] b8(input logic [7:0] d, input logic o);
        return {6'h00, 1'b1, d, ^{1'b1, d} ^ o};
    endfunction

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic check(input string nm, input logic [15:0] seen,
                         input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rc(input logic [2:0] a, input logic [15:0] m,
                      input logic [15:0] e, input string nm);
        rd(a, v);
        check(nm, v & m, e);
    endtask
    task automatic conclude;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Samples n bits mid-bit, times the driver
    task automatic tx_run(input int n, input logic inv, output int dur);
        int t;
        t = 0;
        bits = 64'h0;
        while (line_driver_active !== 1'b1 && t < 200) begin
            @(posedge clk_sys);
            t++;
        end
        dur = 0;
        while (line_driver_active === 1'b1 && dur < 8000) begin
            if (dur % 100 == 50 && dur > 100 && dur < 100 * n + 100)
                bits = {bits[62:0], ser_out ^ inv};
            @(posedge clk_sys);
            dur++;
        end
    endtask

    // Hang guard; the run needs about 11k cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            miscompares++;
            conclude();
        end
    end

    initial begin
        resetn = 1'b0;
        reg_addr = 3'h0;
        reg_wr = 1'b0;
        reg_wdata = 16'h0000;
        reg_rd = 1'b0;
        miscompares = 0;
        num_checks = 0;
        cycles = 0;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        rd(btf_pkg::A_FILL, v);
        check("fill reset", v, {8'h00, btf_pkg::FILL_RST});
        rc(3'h6, 16'hffff, 16'h0000, "unmapped");
        // Two twinax frames, inverted line, two extra fills
        wr(MOD, 16'h0008);
        wr(btf_pkg::A_FILL, 16'h00fd);
        wr(btf_pkg::A_TCN, 16'h000d);
        wr(DAT, 16'h00a5);
        wr(DAT, 16'h003c);
        tx_run(34, 1'b1, d0);
        check("frame one", bits[33:18], tw(8'ha5, 4'hd));
        check("fill gap", 16'(bits[17:16]), 16'h0000);
        check("frame two", bits[15:0], tw(8'h3c, 4'hd));
        // Lone frames; hold counted in half bits
        wr(MOD, 16'h0000);
        wr(btf_pkg::A_TCN, 16'h0002);
        wr(DAT, 16'h0081);
        tx_run(16, 1'b0, d1);
        check("even frame", bits[15:0], tw(8'h81, 4'h2));
        wr(btf_pkg::A_AUX, 16'h0020);
        wr(DAT, 16'h0081);
        tx_run(16, 1'b0, d2);
        check("pair length", 16'(d0 - d1), 16'h0708);
        check("hold step", 16'(d2 - d1), 16'h00c8);
        // Byte mode keeps only parity select
        wr(MOD, 16'h0001);
        for (int i = 0; i < 2; i++) begin
            wr(btf_pkg::A_TCN, (i == 1) ? 16'h000f : 16'h0007);
            wr(DAT, 16'h0096);
            tx_run(10, 1'b0, d1);
            check("byte frame", bits[15:0], b8(8'h96, i[0]));
        end
        // Promiscuous twinax
        wr(MOD, 16'h0002);
        rem.send({1'b1, 8'h81, 3'h3, 4'h0}, 1'b0);
        rem.send({1'b1, 8'h42, 3'h7, 4'h0}, 1'b0);
        rc(STA, 16'h003f, 16'h0033, "head status");
        rc(DAT, 16'h00ff, 16'h0081, "head data");
        rc(STA, 16'h003f, 16'h003f, "last status");
        rc(DAT, 16'h00ff, 16'h0042, "last data");
        rem.lose_sync(1'b0);
        repeat (20) @(posedge clk_sys);
        rc(STA, 16'h00f0, 16'h0040, "turnaround");
        wr(STA, 16'h0040);
        rc(STA, 16'h0040, 16'h0000, "turnaround off");
        // Filtered twinax
        wr(MOD, 16'h0000);
        wr(btf_pkg::A_AUX, 16'h0005);
        rem.send({1'b1, 8'h33, 3'h2, 4'h0}, 1'b0);
        rem.send({1'b1, 8'h11, 3'h5, 4'h0}, 1'b0);
        rem.send({1'b1, 8'h22, 3'h2, 4'h0}, 1'b0);
        rem.lose_sync(1'b1);
        repeat (600) @(posedge clk_sys);
        rc(STA, 16'h009f, 16'h0015, "window open");
        repeat (600) @(posedge clk_sys);
        rc(STA, 16'h009f, 16'h0095, "sync loss");
        rc(DAT, 16'h00ff, 16'h0011, "match data");
        rc(STA, 16'h001f, 16'h0012, "later frame");
        rd(DAT, v);
        // Filtered byte mode
        wr(STA, 16'h0080);
        wr(MOD, 16'h0001);
        wr(btf_pkg::A_AUX, 16'h003c);
        rem.send({6'h00, 8'h11, 2'b10}, 1'b0);
        rc(STA, 16'h0010, 16'h0000, "byte dropped");
        rem.send({6'h00, 8'h3c, 2'b10}, 1'b1);
        rem.send({6'h00, 8'h3c, 2'b10}, 1'b0);
        rc(DAT, 16'h00ff, 16'h003c, "byte data");
        rc(STA, 16'h0010, 16'h0000, "error skipped");
        conclude();
    end
endmodule // biphase_twinax_and_byte_framer_tb

bind btf_framer btf_checker chk (
    .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ser_in(ser_in),
    .ser_out(ser_out), .line_driver_active(line_driver_active),
    .dec_ser_in(dec_ser_in), .dec_hunt(dec_hunt),
    .rx_valid(rx_valid), .rx_err(rx_err));

// >>> btf_framer.sv
// Twinax and 8-bit byte framer with transmit and receive word FIFOs
//
// Functional notes
// - Separate receive and transmit invert mode bits.
// - Twinax address field comes from nibble low bits.
// - Twinax parity over bits 4-15, sent as bit 3.
// - Data write pushes nibble plus byte, starts sender.
// - Control nibble persists across frames until rewritten.
// - Three fill bits end every twinax frame.
// - Extra fill count is inverse of fill register.
// - Last frame sends only its three fill bits.
// - Promiscuous twinax stores every frame with address.
// - Filtered twinax compares first address with aux bits.
// - Mismatched clean first frame returns receiver to hunt.
// - Message end judged by line activity only.
// - Fill sync loss: inactive line ends message, turnaround.
// - Line still active after window flags sync loss.
// - End-of-message marker when received address all ones.
// - Twinax driver enable held per aux upper five bits.
// - Filtered 8-bit compares first byte with aux.
// - Mismatched clean 8-bit first frame returns to hunt.
// - Promiscuous 8-bit stores every frame, no comparison.
// - 8-bit mode keeps only parity select from nibble.
// - 8-bit parity over bits 1-9 sent as bit 0.
// - 8-bit frames stored unchanged, address bits zero.
// - Reading data register advances receive FIFO.
// - Turnaround cleared by data write, write-one, reset bit.
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
module btf_framer #(
    parameter int TXD = 4,
    parameter int RXD = 4
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // Register port
    input  wire logic [2:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // Line pins
    input  wire logic        ser_in,
    input  wire logic        line_activity_indicator,
    output logic             ser_out,
    output logic             line_driver_active,
    // Biphase decoder side
    output logic             dec_ser_in,
    output logic             dec_hunt,
    input  wire logic        rx_valid,
    input  wire logic [15:0] rx_frame,
    input  wire logic        rx_err,
    input  wire logic        rx_fill_lost
);
    localparam int TPW = $clog2(TXD);
    localparam int RPW = $clog2(RXD);
    localparam int TCW = btf_pkg::TCW;
    localparam int BDW = btf_pkg::BDW;
    localparam logic [BDW-1:0] BDM = BDW'(btf_pkg::BIT_CYC - 1);
    localparam logic [TCW-1:0] HCW = TCW'(btf_pkg::HOLD_CYC);
    localparam logic [TCW-1:0] BCW = TCW'(btf_pkg::BIT_CYC);
    localparam logic [TCW-1:0] WCW = TCW'(btf_pkg::WATCH_CYC);

    typedef struct packed {
        logic [7:0]            mode;
        logic [3:0]            tcn;
        logic [7:0]            fill;
        logic [7:0]            aux;
        logic                  line_turnaround_event;
        logic                  sle;
        logic                  ovr;
        logic [TXD-1:0][11:0]  txm;
        logic [TPW:0]          twp;
        logic [TPW:0]          trp;
        logic [RXD-1:0][11:0]  rxm;
        logic [RPW:0]          rwp;
        logic [RPW:0]          rrp;
        btf_pkg::btf_tx_t      txs;
        logic [15:0]           sh;
        logic [7:0]            nb;
        logic [BDW-1:0]        bdiv;
        logic [TCW-1:0]        tcnt;
        btf_pkg::btf_rx_t      rxs;
        logic [TCW-1:0]        rcnt;
        logic                  ra;
        logic                  la1;
        logic                  la2;
        logic                  si1;
        logic                  si2;
        logic                  sout;
        logic                  drv;
        logic                  dsi;
        logic                  hunt;
        logic [15:0]           rdat;
    } btf_st_t;

    btf_st_t s;
    btf_st_t next_s;

    logic        m8;
    logic        tick;
    logic        txe;
    logic        txf;
    logic        rxe;
    logic        rxf;
    logic [11:0] thead;
    logic [11:0] rhead;
    logic [11:0] tpush;
    logic [11:0] tw_hi;
    logic [15:0] tw_frm;
    logic [15:0] b8_frm;
    logic [2:0]  r_addr;
    logic [7:0]  r_twd;
    logic [7:0]  r_b8d;
    logic        r_match;
    logic [11:0] r_entry;
    logic [15:0] stat;

    // Mode decode and FIFO flags
    assign m8    = s.mode[btf_pkg::M_8BIT];
    assign tick  = (s.bdiv == BDM);
    assign txe   = (s.twp == s.trp);
    assign txf   = (s.twp[TPW-1:0] == s.trp[TPW-1:0]) && !txe;
    assign rxe   = (s.rwp == s.rrp);
    assign rxf   = (s.rwp[RPW-1:0] == s.rrp[RPW-1:0]) && !rxe;
    assign thead = s.txm[s.trp[TPW-1:0]];
    assign rhead = s.rxm[s.rrp[RPW-1:0]];

    // Pushed word; 8-bit keeps only parity select
    assign tpush = m8 ? {s.tcn[btf_pkg::C_OWP], 3'h0, reg_wdata[7:0]}
                      : {s.tcn, reg_wdata[7:0]};

    // Twinax frame: start, data, address, parity, fill
    assign tw_hi  = {1'b1, thead[7:0], thead[10:8]};
    assign tw_frm = {tw_hi, (^tw_hi) ^ thead[11], 3'h0};

    // 8-bit frame: start, data, parity
    assign b8_frm = {1'b1, thead[7:0],
                     (^{1'b1, thead[7:0]}) ^ thead[11], 6'h00};

    // Received fields and address match
    assign r_addr  = rx_frame[6:4];
    assign r_twd   = rx_frame[14:7];
    assign r_b8d   = rx_frame[9:2];
    assign r_match = m8 ? (r_b8d == s.aux)
                        : (r_addr == s.aux[2:0]);
    // Address bits read zero in 8-bit mode
    assign r_entry = m8 ? {4'h0, r_b8d}
                        : {&r_addr, r_addr, r_twd};

    // Status; marker valid only with data available
    always_comb begin
        stat = 16'h0000;
        stat[2:0] = rxe ? 3'h0 : rhead[10:8];
        stat[btf_pkg::ST_EOM] = !rxe && rhead[11];
        stat[btf_pkg::ST_DAV] = !rxe;
        stat[btf_pkg::ST_RA]  = s.ra;
        stat[btf_pkg::ST_LTA] = s.line_turnaround_event;
        stat[btf_pkg::ST_SLE] = s.sle;
        stat[btf_pkg::ST_OVR] = s.ovr;
        stat[btf_pkg::ST_TXF] = txf;
        stat[btf_pkg::ST_TXB] = (s.txs != btf_pkg::TX_IDLE);
    end

    // Next-state logic for the whole block
    always_comb begin
        next_s = s;
        // Pin synchronisers; first stage feeds only the second
        next_s.la1 = line_activity_indicator;
        next_s.la2 = s.la1;
        next_s.si1 = ser_in;
        next_s.si2 = s.si1;
        next_s.dsi = s.si2 ^ s.mode[btf_pkg::M_RIN];
        next_s.hunt = 1'b0;
        next_s.rdat = 16'h0000;
        next_s.bdiv = tick ? '0 : s.bdiv + 1'b1;

        // Register writes; clears come before hardware sets
        if (reg_wr) begin
            unique case (reg_addr)
                btf_pkg::A_DATA: begin
                    if (!txf) begin
                        next_s.txm[s.twp[TPW-1:0]] = tpush;
                        next_s.twp = s.twp + 1'b1;
                    end
                    next_s.line_turnaround_event = 1'b0;
                end
                btf_pkg::A_TCN:  next_s.tcn = reg_wdata[3:0];
                btf_pkg::A_STAT: begin
                    // Write one to clear the sticky flags
                    if (reg_wdata[btf_pkg::ST_LTA]) begin
                        next_s.line_turnaround_event = 1'b0;
                    end
                    if (reg_wdata[btf_pkg::ST_SLE]) begin
                        next_s.sle = 1'b0;
                    end
                    if (reg_wdata[btf_pkg::ST_OVR]) begin
                        next_s.ovr = 1'b0;
                    end
                end
                btf_pkg::A_MODE: next_s.mode = reg_wdata[7:0];
                btf_pkg::A_FILL: next_s.fill = reg_wdata[7:0];
                btf_pkg::A_AUX:  next_s.aux  = reg_wdata[7:0];
                default: ;
            endcase
        end

        // Register reads; the data register pops the receive FIFO
        if (reg_rd) begin
            unique case (reg_addr)
                btf_pkg::A_DATA: begin
                    next_s.rdat = {8'h00, rxe ? 8'h00 : rhead[7:0]};
                    if (!rxe) begin
                        next_s.rrp = s.rrp + 1'b1;
                    end
                end
                btf_pkg::A_TCN:  next_s.rdat = {12'h000, s.tcn};
                btf_pkg::A_STAT: next_s.rdat = stat;
                btf_pkg::A_MODE: next_s.rdat = {8'h00, s.mode};
                btf_pkg::A_FILL: next_s.rdat = {8'h00, s.fill};
                btf_pkg::A_AUX:  next_s.rdat = {8'h00, s.aux};
                default:         next_s.rdat = 16'h0000;
            endcase
        end

        // Transmitter; one bit goes out per bit-time tick
        unique case (s.txs)
            btf_pkg::TX_IDLE: begin
                next_s.sout = s.mode[btf_pkg::M_TIN];
                next_s.bdiv = '0;
                if (!txe) begin
                    next_s.drv = 1'b1;
                    next_s.txs = btf_pkg::TX_FRAME;
                    next_s.sh  = m8 ? b8_frm : tw_frm;
                    next_s.nb  = m8 ? btf_pkg::B8_LEN : btf_pkg::TW_LEN;
                    next_s.trp = s.trp + 1'b1;
                end
            end
            btf_pkg::TX_FRAME, btf_pkg::TX_FILL: begin
                if (tick) begin
                    // Fill bits are zeros before inversion
                    next_s.sout = ((s.txs == btf_pkg::TX_FRAME) && s.sh[15])
                                  ^ s.mode[btf_pkg::M_TIN];
                    next_s.sh = {s.sh[14:0], 1'b0};
                    next_s.nb = s.nb - 1'b1;
                    // Decide what follows while the last bit is on the line
                    if (s.nb == 8'h01) begin
                        if (!txe && !m8 && (s.txs == btf_pkg::TX_FRAME)
                            && (s.fill != btf_pkg::FILL_NONE)) begin
                            next_s.txs = btf_pkg::TX_FILL;
                            next_s.nb  = ~s.fill;
                        end else if (!txe) begin
                            next_s.txs = btf_pkg::TX_FRAME;
                            next_s.sh  = m8 ? b8_frm : tw_frm;
                            next_s.nb  = m8 ? btf_pkg::B8_LEN
                                            : btf_pkg::TW_LEN;
                            next_s.trp = s.trp + 1'b1;
                        end else begin
                            // Last bit still needs its full bit time
                            next_s.txs  = btf_pkg::TX_HOLD;
                            next_s.tcnt = m8 ? BCW
                                : TCW'(s.aux[7:3]) * HCW + BCW;
                        end
                    end
                end
            end
            btf_pkg::TX_HOLD: begin
                // Driver stays on through the programmed hold time
                if (s.tcnt != '0) begin
                    next_s.tcnt = s.tcnt - 1'b1;
                end else begin
                    next_s.txs  = btf_pkg::TX_IDLE;
                    next_s.drv  = 1'b0;
                    next_s.sout = s.mode[btf_pkg::M_TIN];
                end
            end
            default: begin
                next_s.txs = btf_pkg::TX_IDLE;
                next_s.drv = 1'b0;
            end
        endcase

        // Receiver; frames arrive already decoded
        unique case (s.rxs)
            btf_pkg::RX_IDLE: begin
                if (rx_valid && !rx_err) begin
                    if (s.mode[btf_pkg::M_PROM] || r_match) begin
                        next_s.rxs = btf_pkg::RX_MSG;
                        next_s.ra  = 1'b1;
                        if (!rxf) begin
                            next_s.rxm[s.rwp[RPW-1:0]] = r_entry;
                            next_s.rwp = s.rwp + 1'b1;
                        end else begin
                            next_s.ovr = 1'b1;
                        end
                    end else begin
                        next_s.hunt = 1'b1;
                    end
                end
            end
            btf_pkg::RX_MSG, btf_pkg::RX_WATCH: begin
                // Later frames pass without any field check
                if (rx_valid && !rx_err) begin
                    next_s.rxs = btf_pkg::RX_MSG;
                    if (!rxf) begin
                        next_s.rxm[s.rwp[RPW-1:0]] = r_entry;
                        next_s.rwp = s.rwp + 1'b1;
                    end else begin
                        next_s.ovr = 1'b1;
                    end
                end else if (s.rxs == btf_pkg::RX_MSG) begin
                    if (rx_fill_lost) begin
                        next_s.rxs  = btf_pkg::RX_WATCH;
                        next_s.rcnt = WCW;
                    end
                end else if (!s.la2) begin
                    // Quiet line: genuine end of message
                    next_s.rxs = btf_pkg::RX_IDLE;
                    next_s.ra  = 1'b0;
                    next_s.line_turnaround_event = 1'b1;
                end else if (s.rcnt == '0) begin
                    // Line still busy: real loss of sync mid-message
                    next_s.rxs = btf_pkg::RX_IDLE;
                    next_s.ra  = 1'b0;
                    next_s.sle = 1'b1;
                end else begin
                    next_s.rcnt = s.rcnt - 1'b1;
                end
            end
            default: begin
                next_s.rxs = btf_pkg::RX_IDLE;
                next_s.ra  = 1'b0;
            end
        endcase

        // Transceiver reset bit holds both paths idle and empty
        if (s.mode[btf_pkg::M_TRANSCEIVER_RESET_BIT]) begin
            next_s.txs  = btf_pkg::TX_IDLE;
            next_s.rxs  = btf_pkg::RX_IDLE;
            next_s.trp  = next_s.twp;
            next_s.rrp  = next_s.rwp;
            next_s.line_turnaround_event  = 1'b0;
            next_s.ra   = 1'b0;
            next_s.drv  = 1'b0;
            next_s.sout = s.mode[btf_pkg::M_TIN];
        end
    end

    // State register; reset values are constants only
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s      <= '0;
            s.mode <= btf_pkg::MODE_RST;
            s.tcn  <= btf_pkg::TCN_RST;
            s.fill <= btf_pkg::FILL_RST;
            s.aux  <= btf_pkg::AUX_RST;
            s.txs  <= btf_pkg::TX_IDLE;
            s.rxs  <= btf_pkg::RX_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata          = s.rdat;
    assign ser_out            = s.sout;
    assign line_driver_active = s.drv;
    assign dec_ser_in         = s.dsi;
    assign dec_hunt           = s.hunt;
endmodule // btf_framer

// >>> btf_framer_properties.sv
// Port checks of the byte framer
`timescale 1ns/1ps
module btf_checker (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        resetn,
    // Register port
    input wire logic [2:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    // Line and decoder side
    input wire logic        ser_in,
    input wire logic        ser_out,
    input wire logic        line_driver_active,
    input wire logic        dec_ser_in,
    input wire logic        dec_hunt,
    input wire logic        rx_valid,
    input wire logic        rx_err
);
    logic [7:0]  mode_sh;
    logic [7:0]  aux_sh;
    logic [1:0]  up_cnt;
    logic [12:0] hi_cnt;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // Mirrored settings; up_cnt masks the sync pipe fill
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mode_sh <= btf_pkg::MODE_RST;
            aux_sh  <= btf_pkg::AUX_RST;
            up_cnt  <= 2'h0;
            hi_cnt  <= 13'h0000;
        end else begin
            if (reg_wr && reg_addr == btf_pkg::A_MODE) begin
                mode_sh <= reg_wdata[7:0];
            end
            if (reg_wr && reg_addr == btf_pkg::A_AUX) begin
                aux_sh <= reg_wdata[7:0];
            end
            up_cnt  <= (up_cnt == 2'h3) ? up_cnt : up_cnt + 2'h1;
            hi_cnt  <= line_driver_active ? hi_cnt + 13'h0001 : 13'h0000;
        end
    end

    AST_RDATA_IDLE: assert property (
        !$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("stray read data");
    AST_UNMAPPED: assert property (
        $past(reg_rd && reg_addr[2:1] == 2'h3) |-> reg_rdata == 16'h0000)
        else $error("unmapped read data");
    AST_AUX_READ: assert property (
        $past(reg_rd && reg_addr == btf_pkg::A_AUX) |->
        reg_rdata == {8'h00, $past(aux_sh)})
        else $error("aux readback");
    AST_DEC_INVERT: assert property (
        up_cnt == 2'h3 |->
        dec_ser_in == ($past(ser_in, 3) ^ $past(mode_sh[btf_pkg::M_RIN])))
        else $error("decoder input wrong");
    AST_IDLE_LEVEL: assert property (
        !line_driver_active && $past(!line_driver_active) &&
        $stable(mode_sh[btf_pkg::M_TIN]) |->
        ser_out == mode_sh[btf_pkg::M_TIN])
        else $error("idle level wrong");
    AST_START_BIT: assert property (
        $rose(line_driver_active) |->
        ##101 ser_out != mode_sh[btf_pkg::M_TIN])
        else $error("start bit missing");
    AST_HUNT_CAUSE: assert property (
        dec_hunt |-> $past(rx_valid && !rx_err && !mode_sh[btf_pkg::M_PROM]))
        else $error("stray hunt pulse");
    AST_MIN_ACTIVE: assert property (
        $fell(line_driver_active) && !mode_sh[btf_pkg::M_TRANSCEIVER_RESET_BIT] |->
        hi_cnt >= 13'h044c)
        else $error("driver released early");
endmodule // btf_checker

// >>> btf_pkg.sv
// Constants and types of the byte framer
package btf_pkg;
    // Clock and line timing
    localparam int CLK_NS     = 10;
    localparam int BIT_NS     = 1000;
    localparam int HOLD_NS    = 500;
    localparam int WATCH_BITS = 11;
    // Cycle counts; times round up
    localparam int BIT_CYC    = (BIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC   = (HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int WATCH_CYC  = WATCH_BITS * BIT_CYC;
    localparam int BDW        = $clog2(BIT_CYC);
    localparam int TCW        = 12;

    // Register offsets on the plain register port
    localparam logic [2:0] A_DATA = 3'h0;
    localparam logic [2:0] A_TCN  = 3'h1;
    localparam logic [2:0] A_STAT = 3'h2;
    localparam logic [2:0] A_MODE = 3'h3;
    localparam logic [2:0] A_FILL = 3'h4;
    localparam logic [2:0] A_AUX  = 3'h5;

    // Reset values
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [3:0] TCN_RST  = 4'h0;
    localparam logic [7:0] FILL_RST = 8'hff;
    localparam logic [7:0] AUX_RST  = 8'h00;
    localparam logic [7:0] FILL_NONE = 8'hff;

    // Mode register bits
    localparam int M_8BIT = 0;
    localparam int M_PROM = 1;
    localparam int M_RIN  = 2;
    localparam int M_TIN  = 3;
    localparam int M_TRANSCEIVER_RESET_BIT = 4;

    // Control nibble: parity select bit
    localparam int C_OWP = 3;

    // Status register bits
    localparam int ST_EOM = 3;
    localparam int ST_DAV = 4;
    localparam int ST_RA  = 5;
    localparam int ST_LTA = 6;
    localparam int ST_SLE = 7;
    localparam int ST_OVR = 8;
    localparam int ST_TXF = 9;
    localparam int ST_TXB = 10;

    // Frame lengths in bit times
    localparam logic [7:0] TW_LEN = 8'h10;
    localparam logic [7:0] B8_LEN = 8'h0a;

    typedef enum logic [1:0] {TX_IDLE, TX_FRAME, TX_FILL, TX_HOLD} btf_tx_t;
    typedef enum logic [1:0] {RX_IDLE, RX_MSG, RX_WATCH} btf_rx_t;
endpackage

// >>> btf_remote.sv
// Remote stations and decoder model
`timescale 1ns/1ps
module btf_remote (
    // Clock
    input  wire logic        clk_sys,
    // Line pins
    output logic             ser_in,
    output logic             line_activity_indicator,
    // Decoded frames
    output logic             rx_valid,
    output logic [15:0]      rx_frame,
    output logic             rx_err,
    output logic             rx_fill_lost
);
    logic [2:0] tog;

    // Line toggles to exercise the input path
    initial begin
        tog = 3'h0;
        ser_in = 1'b0;
        line_activity_indicator = 1'b0;
        rx_valid = 1'b0;
        rx_frame = 16'h0000;
        rx_err = 1'b0;
        rx_fill_lost = 1'b0;
    end
    always @(posedge clk_sys) begin
        tog    <= tog + 3'h1;
        ser_in <= (tog == 3'h0) ? ~ser_in : ser_in;
    end

    // One decoded frame; stale fields inverted
    task automatic send(input logic [15:0] f, input logic err);
        @(posedge clk_sys);
        line_activity_indicator <= 1'b1;
        rx_valid <= 1'b1;
        rx_frame <= f;
        rx_err   <= err;
        @(posedge clk_sys);
        rx_valid <= 1'b0;
        rx_frame <= ~f;
        rx_err   <= ~err;
    endtask

    // Sync lost in fills; line goes quiet or stays busy
    task automatic lose_sync(input logic busy);
        @(posedge clk_sys);
        rx_fill_lost <= 1'b1;
        line_activity_indicator <= busy;
        @(posedge clk_sys);
        rx_fill_lost <= 1'b0;
    endtask
endmodule // btf_remote
